// ---- core/fault_monitor_pkg.sv ----
// constants and carrier types for the fault monitor and scale limit block
package fault_monitor_pkg;

   localparam int REG_W = 16;
   localparam int SEL_W = 3;
   localparam int EXT_W = 4;
   localparam int INT_W = 5;

   localparam logic [7:0]  CFG_ADDR    = 8'h05;
   localparam logic [7:0]  ALARM_ADDR  = 8'h08;
   localparam logic [15:0] CFG_RESET   = 16'h0000;
   localparam logic [15:0] ALARM_RESET = 16'h0000;
   localparam logic [15:0] READ_ZERO   = 16'h0000;

   localparam int EXT_FAULT_DRIVE_EN_BIT = 11;
   localparam int INT_FAULT_DRIVE_EN_BIT = 10;
   localparam int EXT_FAULT_POL_BIT      = 9;
   localparam int INT_FAULT_POL_BIT      = 8;
   localparam int CLIP_EN_BIT            = 6;
   localparam int OVER_SCALE_SEL_LSB     = 3;
   localparam int UNDER_SCALE_SEL_LSB    = 0;

   localparam int EXT_ALARM_LSB    = 0;
   localparam int INT_ALARM_LSB    = 4;
   localparam int POS_LO_ALARM_BIT = 0;
   localparam int NEG_LO_ALARM_BIT = 2;
   localparam int A1_LO_ALARM_BIT  = 7;

   localparam int ADDR_W_MIN = 4;
   localparam int ADDR_W_MAX = 8;

   // external group, msb first so it lands on alarm bits 3..0
   typedef struct packed {
      logic neg_input_high_alarm;
      logic neg_input_low_alarm;
      logic pos_input_high_alarm;
      logic pos_input_low_alarm;
   } ext_cmp_t;

   // internal group, lands on alarm bits 8..4
   typedef struct packed {
      logic a1_sat_high;
      logic a1_sat_low;
      logic a2_sat_high;
      logic a2_sat_low;
      logic a3_common_mode;
   } int_cmp_t;

   typedef struct packed {
      ext_cmp_t ext;
      int_cmp_t intl;
      logic     over_scale_trip;
      logic     under_scale_trip;
      logic     exc_ref_lower;
   } cmp_in_t;

   typedef struct packed {
      cmp_in_t            s1;
      cmp_in_t            s2;
      logic [REG_W-1:0]   cfg;
      logic [REG_W-1:0]   alarm;
      logic [REG_W-1:0]   rdata;
      logic               rvalid;
      logic               force_out;
      logic               rail_high;
      logic               clip_high;
      logic               clip_low;
      logic               use_exc;
   } state_t;

endpackage

// ---- core/fault_monitor.sv ----
// fault monitor, alarm status capture and over/under-scale limit control
//
// Functional notes
// R1: open input sets only its own low alarm
// R2: trip reference excitation-based only while excitation enabled
// R3: internal group flags amplifier saturation, common mode
// R4: host keeps internal group enabled during calibration
// R5: alarm status readable at register 8
// R6: alarm status tracks comparators while output enabled
// R7: alarm status frozen while output disabled
// R8: each group ORed into one fault flag
// R9: config bit 11 gates external fault drive
// R10: config bit 10 gates internal fault drive
// R11: config bit 8 sets internal fault rail
// R12: config bit 9 sets external fault rail
// R13: external polarity wins when both faults active
// R14: enabled fault overrides linear output and clipping
// R15: clipping active only when config bit 6 set
// R16: config bits 5:3 select over-scale ratio
// R17: config bits 2:0 select under-scale ratio
// R18: two comparators clip output high and low
// R19: first amplifier low saturation sets its alarm
// R20: alarm status read-only, writes ignored
`timescale 1ns/1ps
module fault_monitor
#(
   parameter int ADDR_W = 8
)
(
   input  wire logic                                     CLK,
   input  wire logic                                     SRST,
   input  wire fault_monitor_pkg::cmp_in_t               CMP_IN,
   input  wire logic                                     OUTPUT_EN,
   input  wire logic                                     EXCITATION_EN,
   input  wire logic [ADDR_W-1:0]                        REG_ADDR,
   input  wire logic [fault_monitor_pkg::REG_W-1:0]      REG_WDATA,
   input  wire logic                                     REG_WR,
   input  wire logic                                     REG_RD,
   output logic      [fault_monitor_pkg::REG_W-1:0]      REG_RDATA,
   output logic                                          REG_RVALID,
   output logic                                          FAULT_FORCE,
   output logic                                          FAULT_RAIL_HIGH,
   output logic                                          CLIP_EN,
   output logic      [fault_monitor_pkg::SEL_W-1:0]      OVER_SCALE_SEL,
   output logic      [fault_monitor_pkg::SEL_W-1:0]      UNDER_SCALE_SEL,
   output logic                                          CLIP_HIGH,
   output logic                                          CLIP_LOW,
   output logic                                          TRIP_REF_USE_EXC
);
   import fault_monitor_pkg::*;

   generate
      if ((ADDR_W < ADDR_W_MIN) || (ADDR_W > ADDR_W_MAX))
      begin : g_bad_addr_w
         $error("ADDR_W out of range");
      end
   endgenerate

   state_t              st_reg;
   state_t              st_next;
   logic                ext_flag;
   logic                int_flag;
   logic                ext_fire;
   logic                int_fire;
   logic                any_fire;
   logic                cfg_hit;
   logic                alarm_hit;
   logic [REG_W-1:0]    alarm_live;

   // group flags and drive gating
   always_comb
   begin
      ext_flag = |st_reg.s2.ext;                                   // R8
      int_flag = |st_reg.s2.intl;                                  // R8 R3
      ext_fire = ext_flag & st_reg.cfg[EXT_FAULT_DRIVE_EN_BIT];    // R9
      int_fire = int_flag & st_reg.cfg[INT_FAULT_DRIVE_EN_BIT];    // R10
      any_fire = ext_fire | int_fire;
   end

   // each external and internal group comparator owns exactly one alarm bit
   always_comb
   begin
      alarm_live = ALARM_RESET;
      alarm_live[EXT_ALARM_LSB +: EXT_W] = st_reg.s2.ext;          // R1
      alarm_live[INT_ALARM_LSB +: INT_W] = st_reg.s2.intl;         // R3 R19
   end

   // address decode
   always_comb
   begin
      cfg_hit   = 1'b0;
      alarm_hit = 1'b0;
      if (REG_ADDR == ADDR_W'(CFG_ADDR))
      begin
         cfg_hit = 1'b1;
      end
      else if (REG_ADDR == ADDR_W'(ALARM_ADDR))
      begin
         alarm_hit = 1'b1;
      end
   end

   always_comb
   begin
      st_next = st_reg;

      // two-stage synchroniser for the analog comparators
      st_next.s1 = CMP_IN;
      st_next.s2 = st_reg.s1;

      // alarm capture: live while enabled, held otherwise
      if (OUTPUT_EN)
      begin
         st_next.alarm = alarm_live;                               // R6
      end
      else
      begin
         st_next.alarm = st_reg.alarm;                             // R7
      end

      // only the configuration register takes writes
      if (REG_WR && cfg_hit)
      begin
         st_next.cfg = REG_WDATA;                                  // R15 R16 R17
      end

      // read port, one cycle latency
      st_next.rvalid = REG_RD;
      if (REG_RD)
      begin
         if (cfg_hit)
         begin
            st_next.rdata = st_reg.cfg;
         end
         else if (alarm_hit)
         begin
            st_next.rdata = st_reg.alarm;                          // R5
         end
         else
         begin
            st_next.rdata = READ_ZERO;
         end
      end

      // fault drive, external group takes priority
      st_next.force_out = any_fire;                                // R14
      if (ext_fire)
      begin
         st_next.rail_high = st_reg.cfg[EXT_FAULT_POL_BIT];        // R12 R13
      end
      else if (int_fire)
      begin
         st_next.rail_high = st_reg.cfg[INT_FAULT_POL_BIT];        // R11
      end
      else
      begin
         st_next.rail_high = 1'b0;
      end

      // clipping, suppressed while a fault drives the output
      st_next.clip_high = st_reg.cfg[CLIP_EN_BIT] & st_reg.s2.over_scale_trip
                          & ~any_fire;                             // R15 R18 R14
      st_next.clip_low  = st_reg.cfg[CLIP_EN_BIT] & st_reg.s2.under_scale_trip
                          & ~any_fire;                             // R15 R18 R14

      // minimum reference selector for external input comparators
      st_next.use_exc = EXCITATION_EN & st_reg.s2.exc_ref_lower;   // R2

      if (SRST)
      begin
         st_next       = '0;
         st_next.cfg   = CFG_RESET;
         st_next.alarm = ALARM_RESET;
      end
   end

   always_ff @(posedge CLK)
   begin
      st_reg <= st_next;
   end

   // outputs straight from the state register
   always_comb
   begin
      REG_RDATA        = st_reg.rdata;
      REG_RVALID       = st_reg.rvalid;
      FAULT_FORCE      = st_reg.force_out;
      FAULT_RAIL_HIGH  = st_reg.rail_high;
      CLIP_EN          = st_reg.cfg[CLIP_EN_BIT];                  // R15
      OVER_SCALE_SEL   = st_reg.cfg[OVER_SCALE_SEL_LSB +: SEL_W];  // R16
      UNDER_SCALE_SEL  = st_reg.cfg[UNDER_SCALE_SEL_LSB +: SEL_W]; // R17
      CLIP_HIGH        = st_reg.clip_high;
      CLIP_LOW         = st_reg.clip_low;
      TRIP_REF_USE_EXC = st_reg.use_exc;
   end

   // checks
   default clocking cb @(posedge CLK);
   endclocking

   default disable iff (SRST);

   sequence s_pos_lo_held;
      (CMP_IN.ext.pos_input_low_alarm && OUTPUT_EN) [*3];
   endsequence

   sequence s_neg_lo_quiet;
      (!CMP_IN.ext.neg_input_low_alarm && OUTPUT_EN) [*3];
   endsequence

   sequence s_neg_lo_held;
      (CMP_IN.ext.neg_input_low_alarm && OUTPUT_EN) [*3];
   endsequence

   sequence s_a1_lo_held;
      (CMP_IN.intl.a1_sat_low && OUTPUT_EN) [*3];
   endsequence

   sequence s_alarm_read;
      REG_RD && alarm_hit;
   endsequence

   sequence s_cfg_write;
      REG_WR && cfg_hit;
   endsequence

   AST_POS_LO_SETS: assert property ( // R1
      s_pos_lo_held |=> st_reg.alarm[POS_LO_ALARM_BIT])
      else $error("positive low alarm not captured");

   AST_NEG_LO_CLEAR: assert property ( // R1
      s_neg_lo_quiet |=> !st_reg.alarm[NEG_LO_ALARM_BIT])
      else $error("negative low alarm set without its comparator");

   AST_A1_LO_SETS: assert property ( // R19
      s_a1_lo_held |=> st_reg.alarm[A1_LO_ALARM_BIT])
      else $error("first amplifier low saturation not captured");

   AST_ALARM_TRACK: assert property ( // R6
      OUTPUT_EN |=> st_reg.alarm == $past(alarm_live))
      else $error("alarm status not tracking comparators");

   AST_ALARM_FREEZE: assert property ( // R7
      !OUTPUT_EN |=> $stable(st_reg.alarm))
      else $error("alarm status changed while output disabled");

   AST_ALARM_RO: assert property ( // R20
      (REG_WR && alarm_hit && !OUTPUT_EN) |=> $stable(st_reg.alarm) && $stable(st_reg.cfg))
      else $error("write to alarm status had an effect");

   AST_ALARM_READ: assert property ( // R5
      s_alarm_read |=> REG_RVALID && (REG_RDATA == $past(st_reg.alarm)))
      else $error("alarm status read returned wrong data");

   AST_EXT_FORCE: assert property ( // R9
      (st_reg.cfg[EXT_FAULT_DRIVE_EN_BIT] && |st_reg.s2.ext) |=> FAULT_FORCE)
      else $error("enabled external fault did not force output");

   AST_INT_GATED: assert property ( // R10
      (!st_reg.cfg[INT_FAULT_DRIVE_EN_BIT] && !(st_reg.cfg[EXT_FAULT_DRIVE_EN_BIT] && |st_reg.s2.ext))
      |=> !FAULT_FORCE)
      else $error("fault forced with drive disabled");

   AST_INT_POL: assert property ( // R11
      (st_reg.cfg[INT_FAULT_DRIVE_EN_BIT] && |st_reg.s2.intl && !ext_fire)
      |=> FAULT_FORCE && (FAULT_RAIL_HIGH == $past(st_reg.cfg[INT_FAULT_POL_BIT])))
      else $error("internal fault rail wrong");

   AST_EXT_PRIORITY: assert property ( // R13
      (ext_fire && int_fire) |=> FAULT_RAIL_HIGH == $past(st_reg.cfg[EXT_FAULT_POL_BIT]))
      else $error("external polarity did not prevail");

   AST_FAULT_OVER_CLIP: assert property ( // R14
      any_fire |=> !CLIP_HIGH && !CLIP_LOW)
      else $error("clipping active during fault drive");

   AST_CLIP_OFF: assert property ( // R15
      (!st_reg.cfg[CLIP_EN_BIT] && !(REG_WR && cfg_hit)) |=> !CLIP_HIGH && !CLIP_LOW && !CLIP_EN)
      else $error("clipping active while disabled");

   AST_CLIP_LIMIT: assert property ( // R18
      (st_reg.cfg[CLIP_EN_BIT] && st_reg.s2.under_scale_trip && !any_fire) |=> CLIP_LOW)
      else $error("under-scale clip missing");

   AST_SCALE_SEL: assert property ( // R16
      s_cfg_write |=> (OVER_SCALE_SEL == $past(REG_WDATA[OVER_SCALE_SEL_LSB +: SEL_W]))
                      && (UNDER_SCALE_SEL == $past(REG_WDATA[UNDER_SCALE_SEL_LSB +: SEL_W])))
      else $error("scale selection does not follow write"); // R17

   AST_TRIP_REF: assert property ( // R2
      !EXCITATION_EN |=> !TRIP_REF_USE_EXC)
      else $error("excitation reference used while excitation off");

   AST_TRIP_REF_ON: assert property ( // R2
      (EXCITATION_EN && st_reg.s2.exc_ref_lower) |=> TRIP_REF_USE_EXC)
      else $error("excitation reference not selected");

   AST_NEG_LO_SETS: assert property ( // R1
      s_neg_lo_held |=> st_reg.alarm[NEG_LO_ALARM_BIT])
      else $error("negative low alarm not captured");

   AST_INT_FORCE: assert property ( // R10
      (st_reg.cfg[INT_FAULT_DRIVE_EN_BIT] && |st_reg.s2.intl) |=> FAULT_FORCE)
      else $error("enabled internal fault did not force output");

   AST_EXT_GATED: assert property ( // R9
      (!st_reg.cfg[EXT_FAULT_DRIVE_EN_BIT] && !int_fire) |=> !FAULT_FORCE)
      else $error("external fault forced output while gated");

   AST_EXT_POL: assert property ( // R12
      ext_fire |=> FAULT_FORCE && (FAULT_RAIL_HIGH == $past(st_reg.cfg[EXT_FAULT_POL_BIT])))
      else $error("external fault rail wrong");

   AST_RAIL_IDLE: assert property ( // R14
      !any_fire |=> !FAULT_FORCE && !FAULT_RAIL_HIGH)
      else $error("fault drive active without enabled fault");

   AST_CLIP_HIGH_LIMIT: assert property ( // R18
      (st_reg.cfg[CLIP_EN_BIT] && st_reg.s2.over_scale_trip && !any_fire) |=> CLIP_HIGH)
      else $error("over-scale clip missing");

   AST_CLIP_NEEDS_TRIP: assert property ( // R18
      (!st_reg.s2.over_scale_trip && !st_reg.s2.under_scale_trip) |=> !CLIP_HIGH && !CLIP_LOW)
      else $error("clip active without its comparator");

   AST_CFG_WRITE: assert property ( // R15
      s_cfg_write |=> CLIP_EN == $past(REG_WDATA[CLIP_EN_BIT]))
      else $error("clip enable does not follow write");

   AST_RVALID_PULSE: assert property ( // R5
      !REG_RD |=> !REG_RVALID)
      else $error("read valid without read");

   AST_UNMAPPED_READ: assert property ( // R5
      (REG_RD && !cfg_hit && !alarm_hit) |=> REG_RDATA == READ_ZERO)
      else $error("unmapped read not zero");

   AST_RDATA_HOLD: assert property ( // R5
      !REG_RD |=> $stable(REG_RDATA))
      else $error("read data changed without read");

   AST_CFG_READ: assert property ( // R15
      (REG_RD && cfg_hit) |=> REG_RDATA == $past(st_reg.cfg))
      else $error("configuration read returned wrong data");

endmodule

// ---- tb/sensor_model.sv ----
// bridge sensor and amplifier model giving comparator levels for each fault condition
`timescale 1ns/1ps
module sensor_model
(
   input  wire logic                                cond_valid,
   input  wire logic [3:0]                          cond,
   input  wire logic [fault_monitor_pkg::INT_W-1:0] int_flags,
   input  wire logic                                ovr,
   input  wire logic                                und,
   input  wire logic                                exc_low,
   output fault_monitor_pkg::cmp_in_t               cmp
);
   import fault_monitor_pkg::*;

   // condition codes: 1 pos open, 2 neg open, 3 both open (pull-downs), 4 both open no pulls,
   // 5 pos input high, 6 neg input high; external levels change only when the bench changes cond
   always_comb
   begin
      cmp = '0;
      case (cond & {4{cond_valid}})
         4'h1: cmp.ext = 4'b0001;
         4'h2: cmp.ext = 4'b0100;
         4'h3: cmp.ext = 4'b0101;
         4'h4: cmp.intl.a1_sat_low = 1'b1;
         4'h5: cmp.ext = 4'b0010;
         4'h6: cmp.ext = 4'b1000;
         default: cmp.ext = 4'b0000;
      endcase
      cmp.intl = cmp.intl | int_flags;
      cmp.over_scale_trip = ovr;
      cmp.under_scale_trip = und;
      cmp.exc_ref_lower = exc_low;
   end
endmodule

// ---- tb/testbench.sv ----
// self-checking testbench for the fault monitor and scale limit block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
   import fault_monitor_pkg::*;
   localparam int SETTLE = 5;
   logic             clk = 1'b0;
   logic             srst = 1'b1;
   logic             out_en = 1'b1;
   logic             exc_en = 1'b0;
   logic [7:0]       addr = 8'h00;
   logic [REG_W-1:0] wdata = 16'h0000;
   logic             wr = 1'b0;
   logic             rd = 1'b0;
   logic [3:0]       cond = 4'h0;
   logic [INT_W-1:0] int_flags = 5'h00;
   logic             ovr = 1'b0;
   logic             und = 1'b0;
   logic             exc_low = 1'b0;
   cmp_in_t          cmp;
   logic [REG_W-1:0] rdata;
   logic [REG_W-1:0] rd_val;
   logic             rvalid;
   logic             force_o;
   logic             rail_high;
   logic             clip_en;
   logic             clip_high;
   logic             clip_low;
   logic             use_exc;
   logic [SEL_W-1:0] over_sel;
   logic [SEL_W-1:0] under_sel;
   int               error_cnt = 0;
   int               checked = 0;

   always #12.5 clk = ~clk;

   sensor_model partner (.cond_valid(1'b1), .cond(cond), .int_flags(int_flags), .ovr(ovr), .und(und),
                         .exc_low(exc_low), .cmp(cmp));

   fault_monitor #(.ADDR_W(8)) uut (.CLK(clk), .SRST(srst), .CMP_IN(cmp), .OUTPUT_EN(out_en),
      .EXCITATION_EN(exc_en), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdata), .REG_RVALID(rvalid), .FAULT_FORCE(force_o), .FAULT_RAIL_HIGH(rail_high),
      .CLIP_EN(clip_en), .OVER_SCALE_SEL(over_sel), .UNDER_SCALE_SEL(under_sel), .CLIP_HIGH(clip_high),
      .CLIP_LOW(clip_low), .TRIP_REF_USE_EXC(use_exc));

   task automatic reg_write(input logic [7:0] a, input logic [REG_W-1:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask

   task automatic reg_read(input logic [7:0] a);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      `CHK(rvalid, 1'b1)
      rd_val = rdata;
      @(negedge clk);
   endtask

   task automatic t_reset;
      reg_read(CFG_ADDR);
      `CHK(rd_val, CFG_RESET)
      reg_read(ALARM_ADDR);
      `CHK(rd_val, ALARM_RESET)
      reg_read(8'h3C);
      `CHK(rd_val, READ_ZERO)
      `CHK(force_o, 1'b0)
      $display("test reset done");
   endtask

   task automatic t_alarm;
      logic [REG_W-1:0] exp_tab [6] = '{16'h0001, 16'h0004, 16'h0005, 16'h0080, 16'h0002, 16'h0008};
      for (int k = 0; k < 6; k++)
      begin
         cond = 4'(k + 1);
         repeat (SETTLE) @(negedge clk);
         reg_read(ALARM_ADDR);
         `CHK(rd_val, exp_tab[k])
      end
      cond = 4'h0;
      for (int k = 0; k < 5; k++)
      begin
         int_flags = 5'h01 << k;
         repeat (SETTLE) @(negedge clk);
         reg_read(ALARM_ADDR);
         `CHK(rd_val, 16'h0010 << k)
      end
      int_flags = 5'h00;
      $display("test alarm done");
   endtask

   task automatic t_freeze;
      cond = 4'h1;
      repeat (SETTLE) @(negedge clk);
      out_en = 1'b0;
      cond = 4'h2;
      repeat (SETTLE) @(negedge clk);
      reg_read(ALARM_ADDR);
      `CHK(rd_val, 16'h0001)
      reg_write(ALARM_ADDR, 16'hFFFF);
      reg_read(ALARM_ADDR);
      `CHK(rd_val, 16'h0001)
      out_en = 1'b1;
      repeat (SETTLE) @(negedge clk);
      reg_read(ALARM_ADDR);
      `CHK(rd_val, 16'h0004)
      cond = 4'h0;
      repeat (SETTLE) @(negedge clk);
      $display("test freeze done");
   endtask

   task automatic t_fault;
      logic [3:0] ext_cond [4] = '{4'h1, 4'h2, 4'h5, 4'h6};
      logic       e;
      logic       i;
      for (int k = 0; k < 256; k++)
      begin
         reg_write(CFG_ADDR, {4'h0, k[3:0], 8'h00});
         cond = k[4] ? ext_cond[k[7:6]] : 4'h0;
         int_flags = k[5] ? 5'(5'h01 << (k % 5)) : 5'h00;
         repeat (SETTLE) @(negedge clk);
         e = k[4] & k[3];
         i = k[5] & k[2];
         `CHK(force_o, e | i)
         `CHK(rail_high, e ? k[1] : (i & k[0]))
      end
      cond = 4'h0;
      int_flags = 5'h00;
      $display("test fault done");
   endtask

   task automatic t_clip;
      for (int k = 0; k < 32; k++)
      begin
         reg_write(CFG_ADDR, 16'h0400 | {9'h000, k[4], k[2:0], ~k[2:0]});
         ovr = k[3];
         und = ~k[3];
         repeat (SETTLE) @(negedge clk);
         `CHK(clip_en, k[4])
         `CHK(over_sel, k[2:0])
         `CHK(under_sel, ~k[2:0])
         `CHK(clip_high, k[4] & k[3])
         `CHK(clip_low, k[4] & ~k[3])
      end
      reg_write(CFG_ADDR, 16'h0440);
      ovr = 1'b1;
      int_flags = 5'h01;
      repeat (SETTLE) @(negedge clk);
      `CHK(force_o, 1'b1)
      `CHK(clip_high, 1'b0)
      int_flags = 5'h00;
      ovr = 1'b0;
      und = 1'b0;
      $display("test clip done");
   endtask

   task automatic t_exc_ref;
      for (int k = 0; k < 4; k++)
      begin
         exc_en = k[0];
         exc_low = k[1];
         repeat (SETTLE) @(negedge clk);
         `CHK(use_exc, k[0] & k[1])
      end
      $display("test exc_ref done");
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
      begin
         $display("DONE - PASS");
      end
      else
      begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      test_done;
   end

   initial
   begin
      repeat (20) @(negedge clk);
      srst = 1'b0;
      @(negedge clk);
      t_reset;
      t_alarm;
      t_freeze;
      t_fault;
      t_clip;
      t_exc_ref;
      test_done;
   end
endmodule
